// ===== verilog/sgpr_regs.sv
/*
  Status, identifier and advertisement registers of the serial gigabit port PCS,
  reached over APB with no wait state.
  The status word reports completion, partner receive-link-down and the latched
  receive link.
  The advertisement word is the codeword handed to the engine.
  Three extra words hold sticky event flags, their mask and the staged engine
  control together with the mode select.
  Every read is answered from a flip-flop in the cycle after setup, so the
  access phase always lasts exactly one cycle.
  Unmapped or unaligned words answer with pslverr, read as zero and drop writes.
  Assumes the auto-negotiation engine runs on pclk and drives sgpr_an_in_t there,
  so its inputs need no synchroniser.
  Assumes an APB master that keeps psel, paddr, pwrite and pwdata stable from
  setup to completion.
  Read side effects act on the completion edge, not on the setup edge.
  Assumes software writes the advertisement word after changing the staged
  control, since only that write applies it.
*/
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "sgpr_defs.svh"
module sgpr_regs #(
  parameter int PADDR_W = 24,
  parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value.
  parameter logic [15:0] ID_LOW = 16'h5678 // Arbitrary value.
) (
  input wire logic pclk, // APB clock, 10 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [PADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped access
  input wire sgpr_pkg::sgpr_an_in_t an_in, // Engine status
  output logic [15:0] adv_codeword, // Codeword to transmit
  output logic adv_load, // Pulse: new codeword and control
  output logic [`SGPR_CFG_STAGE_W-1:0] an_ctrl, // Applied engine control
  output logic serdes_mode, // 1000BASE-X mode when high
  output logic lp_ability_valid, // Partner ability valid
  output logic sgmii_result_valid, // SGMII results valid
  output logic irq // Interrupt, active high level
);
  import sgpr_pkg::*;

  generate
    if (PADDR_W < `SGPR_MIN_ADDR_W) begin : g_bad_addr
      $error("PADDR_W too narrow for the register map");
    end
  endgenerate

  sgpr_state_t st_ff;
  sgpr_state_t nxt_st;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic [`SGPR_IDX_W-1:0] idx;
  logic aligned;
  logic hit;
  logic [15:0] rmux;
  logic [15:0] stat_word;
  logic [`SGPR_IRQ_W-1:0] ev;

  // ------------------------------------------------------------------
  // Address decode and read mux
  // ------------------------------------------------------------------
  // Reads are sampled in the setup cycle and answered one cycle later so
  // that prdata is a flip-flop. The latched bits remember what was shown
  // so that an event landing in the wait cycle is not cleared unseen.
  assign idx = paddr[`SGPR_IDX_W+1:2];
  assign aligned = (paddr[1:0] == 2'h0);

  always_comb begin
    stat_word = `SGPR_STATUS_FIXED;
    stat_word[`SGPR_ST_DONE_BIT] = st_ff.an_done;
    stat_word[`SGPR_ST_RFAULT_BIT] = st_ff.rfault;
    stat_word[`SGPR_ST_LINK_BIT] = st_ff.link_ll;
    hit = aligned;
    rmux = 16'h0000;
    case (idx)
      `SGPR_IDX_STATUS: rmux = stat_word;
      `SGPR_IDX_ID_HIGH: rmux = ID_HIGH;
      `SGPR_IDX_ID_LOW: rmux = ID_LOW;
      `SGPR_IDX_ADVERT: rmux = st_ff.adv_word;
      `SGPR_IDX_IRQ_STATUS: rmux = {13'h0000, st_ff.irq_st};
      `SGPR_IDX_IRQ_MASK: rmux = {13'h0000, st_ff.irq_mask};
      `SGPR_IDX_AN_CONFIG: rmux = {7'h00, st_ff.serdes, st_ff.cfg_stage};
      default: hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    setup = psel & ~penable;
    done = psel & penable & st_ff.pready;
    wr = done & pwrite & hit;
    rd = done & ~pwrite & hit & (idx == `SGPR_IDX_STATUS);
    nxt_st.pready = setup;
    nxt_st.adv_load = 1'b0;
    if (setup) begin
      // Refused words read as zero so that stale data never leaks out.
      nxt_st.prdata = (pwrite | ~hit) ? 16'h0000 : rmux;
      nxt_st.pslverr = ~hit;
      nxt_st.snap_ll = st_ff.link_ll;
      nxt_st.snap_rf = st_ff.rfault;
    end else if (done) begin
      nxt_st.pslverr = 1'b0;
    end
    nxt_st.an_done = an_in.an_complete;
    nxt_st.rx_up_d = an_in.rx_link_up;
    // A drop seen after the shown value survives the clearing read.
    if (rd) begin
      nxt_st.link_ll = an_in.rx_link_up & (st_ff.link_ll | ~st_ff.snap_ll);
    end else begin
      nxt_st.link_ll = st_ff.link_ll & an_in.rx_link_up;
    end
    // Only a fault that was read is cleared; a new one sets it again.
    nxt_st.rfault = (st_ff.rfault & ~(rd & st_ff.snap_rf))
                    | (st_ff.serdes & an_in.lp_rx_link_down);
    // Both valid flags use the same mode sample, so exactly one of them rises
    // with completion and a mode change cannot show both at once.
    nxt_st.lp_valid = an_in.an_complete & st_ff.serdes;
    nxt_st.sg_valid = an_in.an_complete & ~st_ff.serdes;
    // Events are single-cycle strobes; the partner fault counts every cycle
    // it is signalled in 1000BASE-X mode, and a drop is the falling edge of the live link.
    ev = '0;
    ev[`SGPR_IRQ_DONE] = an_in.an_complete & ~st_ff.an_done;
    ev[`SGPR_IRQ_RFAULT] = st_ff.serdes & an_in.lp_rx_link_down;
    ev[`SGPR_IRQ_DROP] = st_ff.rx_up_d & ~an_in.rx_link_up;
    nxt_st.irq_st = st_ff.irq_st | ev;
    // Writes land on the completion edge only; status and identifier words
    // have no branch here, so writes to them are ignored without an error.
    if (wr) begin
      case (idx)
        `SGPR_IDX_ADVERT: begin
          // Bit 15 and reserved bits are outside the mask and stay fixed.
          nxt_st.adv_word = (pwdata[15:0] & `SGPR_ADV_WMASK)
                            | (st_ff.adv_word & ~`SGPR_ADV_WMASK);
          nxt_st.cfg_active = st_ff.cfg_stage;
          nxt_st.adv_load = 1'b1;
        end
        `SGPR_IDX_IRQ_STATUS: begin
          // Set wins: an event in the clearing cycle stays pending.
          nxt_st.irq_st = (st_ff.irq_st & ~pwdata[`SGPR_IRQ_W-1:0]) | ev;
        end
        `SGPR_IDX_IRQ_MASK: nxt_st.irq_mask = pwdata[`SGPR_IRQ_W-1:0];
        `SGPR_IDX_AN_CONFIG: begin
          nxt_st.cfg_stage = pwdata[`SGPR_CFG_STAGE_W-1:0];
          nxt_st.serdes = pwdata[`SGPR_CFG_MODE_BIT];
        end
        default: nxt_st.irq_mask = st_ff.irq_mask;
      endcase
    end
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.adv_word <= `SGPR_ADV_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = {16'h0000, st_ff.prdata};
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign adv_codeword = st_ff.adv_word;
  assign adv_load = st_ff.adv_load;
  assign an_ctrl = st_ff.cfg_active;
  assign serdes_mode = st_ff.serdes;
  assign lp_ability_valid = st_ff.lp_valid;
  assign sgmii_result_valid = st_ff.sg_valid;
  assign irq = st_ff.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // All checks sit on pclk and are quiet while reset is applied, so the
  // first edge after release compares against the reset image only.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------------
  // The completed bit is a one-cycle delayed copy of the engine level.
  a_done_follows: assert property (
    an_in.an_complete |=> st_ff.an_done)
    else $error("completed bit did not follow engine");

  a_done_clear: assert property (
    !an_in.an_complete |=> !st_ff.an_done)
    else $error("completed bit set without engine");

  a_valid_mode: assert property (
    st_ff.an_done && st_ff.serdes == $past(st_ff.serdes) |-> (lp_ability_valid != sgmii_result_valid))
    else $error("result valid flags disagree with mode");

  a_valid_done: assert property (
    lp_ability_valid || sgmii_result_valid |-> st_ff.an_done)
    else $error("results flagged valid before completion");

  a_lp_valid: assert property (
    lp_ability_valid |-> $past(st_ff.serdes))
    else $error("partner ability valid outside serdes mode");

  a_sg_valid: assert property (
    sgmii_result_valid |-> !$past(st_ff.serdes))
    else $error("sgmii results valid in serdes mode");

  // The fault bit may only fall on a status read that showed it.
  a_rfault_hold: assert property (
    st_ff.rfault && !rd |=> st_ff.rfault)
    else $error("remote fault dropped without read");

  a_rfault_set: assert property (
    st_ff.serdes && an_in.lp_rx_link_down |=> st_ff.rfault)
    else $error("partner link down not latched");

  a_rfault_read: assert property (
    rd && st_ff.snap_rf && !(st_ff.serdes && an_in.lp_rx_link_down) |=> !st_ff.rfault)
    else $error("remote fault survived its read");

  a_rfault_sgmii: assert property (
    !st_ff.serdes && !st_ff.rfault && !wr |=> !st_ff.rfault)
    else $error("remote fault set in sgmii mode");

  a_link_up: assert property (
    st_ff.link_ll |-> $past(an_in.rx_link_up))
    else $error("link bit high while link was down");

  a_link_latch: assert property (
    !an_in.rx_link_up ##1 !rd [*2] |-> !st_ff.link_ll)
    else $error("link drop not latched low");

  // Only a clearing read may lift the latched low level.
  a_link_stay: assert property (
    !st_ff.link_ll && !rd |=> !st_ff.link_ll)
    else $error("link bit rose without status read");

  a_link_read: assert property (
    rd && an_in.rx_link_up && !st_ff.snap_ll |=> st_ff.link_ll)
    else $error("link bit not reloaded by read");

  a_status_rsvd: assert property (
    $past(setup && !pwrite && hit && idx == `SGPR_IDX_STATUS)
      |-> (prdata[15:0] & `SGPR_STATUS_FMASK) == `SGPR_STATUS_FIXED)
    else $error("status reserved bits wrong");

  // ------------------------------------------------------------------
  // Identifier words
  // ------------------------------------------------------------------
  // The identifier values are parameters; writes have no path to them.
  a_id_high: assert property (
    $past(setup && !pwrite && hit && idx == `SGPR_IDX_ID_HIGH)
      |-> prdata[15:0] == ID_HIGH)
    else $error("upper identifier word wrong");

  a_id_low: assert property (
    $past(setup && !pwrite && hit && idx == `SGPR_IDX_ID_LOW)
      |-> prdata[15:0] == ID_LOW)
    else $error("lower identifier word wrong");

  // ------------------------------------------------------------------
  // Advertisement word and applied control
  // ------------------------------------------------------------------
  // The codeword seen by the engine and the read value are one register.
  a_adv_np: assert property (
    adv_codeword[15] == 1'b0 && adv_codeword[14] == 1'b0)
    else $error("next page bit not zero");

  a_adv_rsvd: assert property (
    (adv_codeword & ~`SGPR_ADV_WMASK) == 16'h0000)
    else $error("advertisement reserved bits not zero");

  a_adv_read: assert property (
    $past(setup && !pwrite && hit && idx == `SGPR_IDX_ADVERT)
      |-> prdata[15:0] == $past(adv_codeword))
    else $error("advertisement read differs from codeword");

  a_adv_hold: assert property (
    !$past(wr && idx == `SGPR_IDX_ADVERT) |-> $stable(adv_codeword))
    else $error("codeword changed without write");

  a_adv_load: assert property (
    wr && idx == `SGPR_IDX_ADVERT |=> adv_load
      && adv_codeword[13:5] == ($past(pwdata[13:5]) & 9'h18F))
    else $error("codeword not loaded from write");

  // Two writes are at least two cycles apart, so loads never merge.
  a_load_pulse: assert property (
    adv_load |=> !adv_load)
    else $error("load strobe longer than one cycle");

  a_ctrl_apply: assert property (
    !$past(wr && idx == `SGPR_IDX_ADVERT) |-> $stable(an_ctrl))
    else $error("control applied without advertisement write");

  a_ctrl_value: assert property (
    wr && idx == `SGPR_IDX_ADVERT |=> an_ctrl == $past(st_ff.cfg_stage))
    else $error("applied control differs from staged");

  a_cfg_mode: assert property (
    wr && idx == `SGPR_IDX_AN_CONFIG |=> serdes_mode == $past(pwdata[`SGPR_CFG_MODE_BIT]))
    else $error("mode select not taken from write");

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  // Ready is a registered copy of the setup phase and stands one cycle.
  a_apb_wait: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");

  a_idle_ready: assert property (
    !psel |=> !pready)
    else $error("ready without a selected transfer");

  a_err_flag: assert property (
    $past(setup && !hit) |-> pslverr && prdata == 32'h0000_0000)
    else $error("refused access not flagged");

  a_ok_flag: assert property (
    $past(setup && hit) |-> !pslverr)
    else $error("error flag on a mapped access");

  a_err_clear: assert property (
    psel && penable && pready |=> !pready && !pslverr)
    else $error("answer stood past completion");

  a_err_nowrite: assert property (
    psel && penable && pready && !hit |=> $stable(adv_codeword) && $stable(an_ctrl)
      && $stable(st_ff.irq_mask) && $stable(serdes_mode))
    else $error("refused write changed a register");

  // ------------------------------------------------------------------
  // Interrupt flags
  // ------------------------------------------------------------------
  // A set in the clearing cycle must survive, or an event is lost unseen.
  a_irq_level: assert property (
    irq == |(st_ff.irq_st & st_ff.irq_mask))
    else $error("interrupt level disagrees with flags");

  a_irq_set: assert property (
    |ev |=> (st_ff.irq_st & $past(ev)) == $past(ev))
    else $error("event flag not set");

  a_irq_sticky: assert property (
    !(wr && idx == `SGPR_IDX_IRQ_STATUS)
      |=> (st_ff.irq_st & $past(st_ff.irq_st)) == $past(st_ff.irq_st))
    else $error("event flag dropped without clear");

  a_irq_clear: assert property (
    wr && idx == `SGPR_IDX_IRQ_STATUS && ev == '0
      |=> (st_ff.irq_st & $past(pwdata[`SGPR_IRQ_W-1:0])) == '0)
    else $error("event flag not cleared by write");

endmodule : sgpr_regs

// ===== verilog/sgpr_defs.svh
/*
  Constants of the serial gigabit port PCS status and advertisement register bank.
  Assumes it is included once per compile unit by its bare name.
*/
// Summary of operation
// - Completed bit 5 sets once acknowledge codewords were exchanged; zero before.
// - While completed, partner ability (1000BASE-X) or SGMII results are flagged valid.
// - Status bit 4 latches high on partner receive-link-down until read.
// - Remote-fault indication is driven only in 1000BASE-X mode.
// - Status bit 2 shows receive link up regardless of auto-negotiation.
// - A link drop latches bit 2 low until status read, then it follows.
// - Advertisement fields form the transmitted codeword in 1000BASE-X mode.
// - Auto-negotiation control changes apply only when advertisement is written; the mode select bit takes effect at once on its own control word write.
// - Advertisement bit 15, next page, always reads zero.
// - Writable remote-fault field at bits 13:12, reset 00b.
// - Writable pause field at bits 8:7, reset 00b.
// - Writable half-duplex bit 6, reset 0.
// - Writable full-duplex bit 5, reset 1.
`ifndef SGPR_DEFS_SVH
`define SGPR_DEFS_SVH

// ------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ------------------------------------------------------------------
`define SGPR_IDX_W 22
`define SGPR_IDX_STATUS 22'h1F0001
`define SGPR_IDX_ID_HIGH 22'h1F0002
`define SGPR_IDX_ID_LOW 22'h1F0003
`define SGPR_IDX_ADVERT 22'h1F0004
`define SGPR_IDX_IRQ_STATUS 22'h1F0010
`define SGPR_IDX_IRQ_MASK 22'h1F0011
`define SGPR_IDX_AN_CONFIG 22'h1F0012

// ------------------------------------------------------------------
// Field layouts and reset values
// ------------------------------------------------------------------
`define SGPR_STATUS_FIXED 16'h0189
`define SGPR_STATUS_FMASK 16'hFFCB
`define SGPR_ST_DONE_BIT 5
`define SGPR_ST_RFAULT_BIT 4
`define SGPR_ST_LINK_BIT 2
`define SGPR_ADV_RESET 16'h0020
`define SGPR_ADV_WMASK 16'h31E0
`define SGPR_CFG_STAGE_W 8
`define SGPR_CFG_MODE_BIT 8
`define SGPR_IRQ_W 3
`define SGPR_IRQ_DONE 0
`define SGPR_IRQ_RFAULT 1
`define SGPR_IRQ_DROP 2
`define SGPR_MIN_ADDR_W 24

`endif

// ===== verilog/sgpr_pkg.sv
/*
  Types of the serial gigabit port PCS register bank.
  Assumes sgpr_defs.svh is compiled alongside.
*/
`include "sgpr_defs.svh"
package sgpr_pkg;

  typedef struct packed {
    logic an_complete;
    logic rx_link_up;
    logic lp_rx_link_down;
  } sgpr_an_in_t;

  typedef struct packed {
    logic link_ll;
    logic rfault;
    logic an_done;
    logic rx_up_d;
    logic snap_ll;
    logic snap_rf;
    logic [15:0] adv_word;
    logic adv_load;
    logic [`SGPR_CFG_STAGE_W-1:0] cfg_stage;
    logic [`SGPR_CFG_STAGE_W-1:0] cfg_active;
    logic serdes;
    logic lp_valid;
    logic sg_valid;
    logic [`SGPR_IRQ_W-1:0] irq_st;
    logic [`SGPR_IRQ_W-1:0] irq_mask;
    logic irq;
    logic [15:0] prdata;
    logic pready;
    logic pslverr;
  } sgpr_state_t;

endpackage : sgpr_pkg

// ===== test/sgpr_an_model.sv
/*
  Behavioural auto-negotiation engine and link partner beside the register bank.
  Assumes it runs on pclk and that the bench steers link and remote-fault state.
*/
`timescale 1ns/1ps
module sgpr_an_model #(
  parameter int ACK_DELAY = 6
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic adv_load, // New codeword and control applied
  input wire logic link_req, // Bench wants the receive link up
  input wire logic lpd_req, // Bench wants partner link-down signalled
  output sgpr_pkg::sgpr_an_in_t an_in // Engine status to the bank
);
  // ------------------------------------------------------------------
  // Negotiation
  // ------------------------------------------------------------------
  // Acknowledge only arrives while the link is up, so a slow link stalls completion.
  logic [7:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
      an_in <= '0;
    end else begin
      an_in.rx_link_up <= link_req;
      an_in.lp_rx_link_down <= lpd_req;
      if (adv_load) begin
        an_in.an_complete <= 1'b0;
        cnt_ff <= 8'(ACK_DELAY);
      end else if (cnt_ff != 8'h00 && link_req) begin
        cnt_ff <= cnt_ff - 8'h01;
        an_in.an_complete <= (cnt_ff == 8'h01);
      end
    end
  end
endmodule : sgpr_an_model

// ===== test/sgpr_regs_test.sv
/*
  Self-checking bench of the PCS status and advertisement register bank.
  Assumes the engine model and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "sgpr_defs.svh"
module sgpr_regs_test;
  import sgpr_pkg::*;
  localparam logic [23:0] a_st = {`SGPR_IDX_STATUS, 2'b00};
  localparam logic [23:0] a_idh = {`SGPR_IDX_ID_HIGH, 2'b00};
  localparam logic [23:0] a_idl = {`SGPR_IDX_ID_LOW, 2'b00};
  localparam logic [23:0] a_adv = {`SGPR_IDX_ADVERT, 2'b00};
  localparam logic [23:0] a_ist = {`SGPR_IDX_IRQ_STATUS, 2'b00};
  localparam logic [23:0] a_msk = {`SGPR_IDX_IRQ_MASK, 2'b00};
  localparam logic [23:0] a_cfg = {`SGPR_IDX_AN_CONFIG, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic link_req = 0, lpd_req = 0, rd_er, ld, pready, pslverr, adv_load;
  logic serdes_mode, lp_ability_valid, sgmii_result_valid, irq;
  logic [23:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic [15:0] adv_codeword;
  logic [7:0] an_ctrl;
  sgpr_an_in_t an_in;
  int num_errors = 0, num_checks = 0, n;
  always #50 pclk = ~pclk;
  sgpr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .an_in(an_in), .adv_codeword(adv_codeword), .adv_load(adv_load),
    .an_ctrl(an_ctrl), .serdes_mode(serdes_mode), .lp_ability_valid(lp_ability_valid),
    .sgmii_result_valid(sgmii_result_valid), .irq(irq));
  sgpr_an_model u_eng (.pclk(pclk), .presetn(presetn), .adv_load(adv_load),
    .link_req(link_req), .lpd_req(lpd_req), .an_in(an_in));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] st_exp(input logic dn, input logic rf, input logic lk);
    return 32'h0000_0189 | {26'h0, dn, rf, 1'b0, lk, 2'b00};
  endfunction : st_exp
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // Ends one edge after completion so adv_load is seen in its pulse cycle.
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] wd);
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    rd_er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    ld = adv_load;
  endtask : apb
  task automatic rchk(input logic [23:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    d = $urandom(32'hC77B);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({16'h0, adv_codeword}, 32'h20);
    rchk(a_adv, 32'h20);
    rchk(a_st, st_exp(0, 0, 0));
    apb(1'b1, a_idh, 32'hFFFF_FFFF);
    rchk(a_idh, 32'h1234);
    apb(1'b1, a_idl, 32'h0);
    rchk(a_idl, 32'h5678);
    apb(1'b1, a_st, 32'hFFFF_FFFF);
    rchk(a_st, st_exp(0, 0, 0));
    apb(1'b0, 24'h00_0100, 32'h0);
    chk(rd_er, 1'b1);
    link_req <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk(a_st, st_exp(0, 0, 0));
    rchk(a_st, st_exp(0, 0, 1));
    apb(1'b1, a_cfg, 32'h1A5);
    chk(an_ctrl, 32'h0);
    chk(serdes_mode, 1'b1);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      apb(1'b1, a_adv, d);
      chk(ld, 1'b1);
      chk({16'h0, adv_codeword}, d & 32'h31E0);
      rchk(a_adv, d & 32'h31E0);
    end
    chk(an_ctrl, 32'hA5);
    rchk(a_st, st_exp(0, 0, 1));
    n = 0;
    while (an_in.an_complete !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 50, 1'b1);
    rchk(a_st, st_exp(1, 0, 1));
    chk(lp_ability_valid, 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, a_msk, 32'h7);
    chk(irq, 1'b1);
    rchk(a_ist, 32'h1);
    apb(1'b1, a_ist, 32'h1);
    chk(irq, 1'b0);
    lpd_req <= 1'b1;
    repeat (2) @(posedge pclk);
    lpd_req <= 1'b0;
    repeat (2) @(posedge pclk);
    rchk(a_st, st_exp(1, 1, 1));
    rchk(a_st, st_exp(1, 0, 1));
    apb(1'b1, a_cfg, 32'h0);
    chk(serdes_mode, 1'b0);
    lpd_req <= 1'b1;
    repeat (2) @(posedge pclk);
    lpd_req <= 1'b0;
    rchk(a_st, st_exp(1, 0, 1));
    chk({lp_ability_valid, sgmii_result_valid}, 32'h1);
    link_req <= 1'b0;
    repeat (2) @(posedge pclk);
    link_req <= 1'b1;
    repeat (2) @(posedge pclk);
    rchk(a_st, st_exp(1, 0, 0));
    rchk(a_st, st_exp(1, 0, 1));
    end_sim();
  end
endmodule : sgpr_regs_test
